/* design/psr_host.sv */
// Host end: register port, serial clock and conversion clock dividers, transaction sequencer
`timescale 1ns/1ps
module psr_host #(
   parameter int SCLK_HALF = psr_pkg::SCLK_HALF_CYC,
   parameter int MCLK_HALF = psr_pkg::MCLK_HALF_CYC,
   parameter bit RESET_FIRST = 1'b1
) (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic reset_in,
   // Register port
   input wire logic [1:0] reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic reg_write_in,
   input wire logic reg_read_in,
   output logic [15:0] reg_rdata_out,
   // Serial link
   psr_link_if.host link
);
   localparam logic [7:0] SCLK_LAST = 8'(SCLK_HALF - 1);
   localparam logic [11:0] MCLK_LAST = 12'(MCLK_HALF - 1);

   typedef enum logic [2:0] {
      H_IDLE,
      H_SEND,
      H_ACK,
      H_EOC,
      H_READ
   } psr_host_state_e;

   typedef struct packed {
      psr_host_state_e state;
      logic [2:0] op;
      logic pend_cmd;
      logic [20:0] shift;
      logic [4:0] bit_cnt;
      logic [7:0] half_cnt;
      logic hold;
      logic [11:0] mclk_cnt;
      logic sclk;
      logic din;
      logic mclk;
      logic [1:0] dout_sync;
      logic [15:0] rx;
      logic [15:0] result;
      logic done;
      logic [15:0] rdata;
   } psr_host_s;

   psr_host_s state_reg;
   psr_host_s state_next;

   // Instruction code for a host operation
   function automatic logic [3:0] op_code(input logic [2:0] op);
      case (op)
         psr_pkg::HOP_TEMPERATURE: op_code = psr_pkg::OP_TEMPERATURE;
         psr_pkg::HOP_CAL_A: op_code = psr_pkg::OP_CAL_A;
         psr_pkg::HOP_CAL_B: op_code = psr_pkg::OP_CAL_B;
         psr_pkg::HOP_CAL_C: op_code = psr_pkg::OP_CAL_C;
         psr_pkg::HOP_CAL_D: op_code = psr_pkg::OP_CAL_D;
         default: op_code = psr_pkg::OP_PRESSURE;
      endcase
   endfunction

   // Next-state logic
   always_comb
   begin
      logic dout_s;
      logic is_conv;
      logic [20:0] cmd_bits;
      logic falling;
      state_next = state_reg;
      state_next.rdata = 16'h0000;
      state_next.dout_sync = {state_reg.dout_sync[0], link.dout};
      dout_s = state_reg.dout_sync[1];
      is_conv = (state_reg.op == psr_pkg::HOP_PRESSURE) || (state_reg.op == psr_pkg::HOP_TEMPERATURE);
      cmd_bits = {psr_pkg::START_BITS, op_code(state_reg.op), psr_pkg::STOP_BITS, 11'h000};
      falling = 1'b0;

      // Free-running conversion clock
      state_next.mclk_cnt = state_reg.mclk_cnt + 12'h001;
      if (state_reg.mclk_cnt == MCLK_LAST)
      begin
         state_next.mclk_cnt = 12'h000;
         state_next.mclk = ~state_reg.mclk;
      end

      // Register reads; reading status clears done, a later set wins
      if (reg_read_in)
      begin
         case (reg_addr_in)
            psr_pkg::REG_CMD: state_next.rdata = {13'h0000, state_reg.op};
            psr_pkg::REG_STATUS:
            begin
               state_next.rdata[psr_pkg::STAT_BUSY_BIT] = (state_reg.state != H_IDLE);
               state_next.rdata[psr_pkg::STAT_DONE_BIT] = state_reg.done;
               state_next.done = 1'b0;
            end
            psr_pkg::REG_RESULT: state_next.rdata = state_reg.result;
            default: state_next.rdata = 16'h0000;
         endcase
      end

      // Serial clock divider runs while a transfer clocks; host moves on falling edges
      if (state_reg.state == H_SEND || state_reg.state == H_ACK || state_reg.state == H_READ)
      begin
         state_next.half_cnt = state_reg.half_cnt + 8'h01;
         if (state_reg.half_cnt == SCLK_LAST)
         begin
            state_next.half_cnt = 8'h00;
            state_next.hold = 1'b0;
            // A held half period passes with no edge
            if (!state_reg.hold)
            begin
               state_next.sclk = ~state_reg.sclk;
               falling = state_reg.sclk;
            end
         end
      end

      unique case (state_reg.state)
         H_IDLE:
         begin
            state_next.sclk = 1'b0;
            state_next.din = 1'b0;
            state_next.half_cnt = 8'h00;
            // New operation only when idle, so results are always drained first
            if (reg_write_in && reg_addr_in == psr_pkg::REG_CMD && reg_wdata_in[2:0] <= psr_pkg::HOP_RESET)
            begin
               state_next.op = reg_wdata_in[2:0];
               state_next.state = H_SEND;
               if (reg_wdata_in[2:0] == psr_pkg::HOP_RESET ||
                   (RESET_FIRST && reg_wdata_in[2:0] <= psr_pkg::HOP_TEMPERATURE))
               begin
                  state_next.shift = psr_pkg::RESET_PATTERN;
                  state_next.din = psr_pkg::RESET_PATTERN[20];
                  state_next.bit_cnt = 5'(psr_pkg::RESET_LEN);
                  state_next.pend_cmd = (reg_wdata_in[2:0] != psr_pkg::HOP_RESET);
               end
               else
               begin
                  state_next.shift = {psr_pkg::START_BITS, op_code(reg_wdata_in[2:0]), psr_pkg::STOP_BITS, 11'h000};
                  state_next.din = psr_pkg::START_BITS[2];
                  state_next.bit_cnt = 5'(psr_pkg::CMD_LEN);
                  state_next.pend_cmd = 1'b0;
               end
            end
         end
         H_SEND:
         begin
            if (falling)
            begin
               state_next.shift = {state_reg.shift[19:0], 1'b0};
               state_next.din = state_reg.shift[19];
               state_next.bit_cnt = state_reg.bit_cnt - 5'h01;
               if (state_reg.bit_cnt == 5'h01)
               begin
                  state_next.din = 1'b0;
                  if (state_reg.pend_cmd)
                  begin
                     state_next.pend_cmd = 1'b0;
                     state_next.shift = cmd_bits;
                     state_next.din = cmd_bits[20];
                     state_next.bit_cnt = 5'(psr_pkg::CMD_LEN);
                  end
                  else if (state_reg.op == psr_pkg::HOP_RESET)
                  begin
                     state_next.done = 1'b1;
                     state_next.state = H_IDLE;
                  end
                  else if (is_conv)
                  begin
                     state_next.state = H_ACK;
                     state_next.bit_cnt = dout_s ? 5'(psr_pkg::ACK_CLOCKS) : 5'h00;
                  end
                  else
                  begin
                     state_next.state = H_READ; // Calibration words
                     state_next.bit_cnt = 5'(psr_pkg::READ_CLOCKS);
                  end
               end
            end
         end
         H_ACK:
         begin
            // Wait for acknowledge, give two clocks, then hold low
            if (falling)
            begin
               if (state_reg.bit_cnt == 5'h00)
               begin
                  state_next.bit_cnt = dout_s ? 5'(psr_pkg::ACK_CLOCKS) : 5'h00;
               end
               else
               begin
                  state_next.bit_cnt = state_reg.bit_cnt - 5'h01;
                  if (state_reg.bit_cnt == 5'h01)
                     state_next.state = H_EOC;
               end
            end
         end
         H_EOC:
         begin
            // Falling data output ends the conversion
            state_next.half_cnt = 8'h00;
            if (!dout_s)
            begin
               state_next.state = H_READ;
               state_next.bit_cnt = 5'(psr_pkg::READ_CLOCKS);
            end
         end
         H_READ:
         begin
            // Seventeen clocks, first sixteen falling edges capture data
            if (falling)
            begin
               state_next.bit_cnt = state_reg.bit_cnt - 5'h01;
               // Pause the clock low mid-word; the sensor must keep its place
               if (state_reg.bit_cnt == 5'h09)
               begin
                  state_next.hold = 1'b1;
               end
               if (state_reg.bit_cnt == 5'h01)
               begin
                  state_next.result = state_reg.rx;
                  state_next.done = 1'b1;
                  state_next.state = H_IDLE;
               end
               else
               begin
                  state_next.rx = {state_reg.rx[14:0], dout_s};
               end
            end
         end
      endcase
   end

   // State register
   always_ff @(posedge core_clk_in)
   begin
      if (reset_in)
      begin
         state_reg <= '0;
         state_reg.state <= H_IDLE;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // Outputs straight from flops
   assign link.sclk = state_reg.sclk;
   assign link.din = state_reg.din;
   assign link.mclk = state_reg.mclk;
   assign reg_rdata_out = state_reg.rdata;
endmodule // psr_host

/* inc/psr_pkg.sv */
// Shared constants for the pressure sensor serial link and its host controller
package psr_pkg;
   // Instruction codes placed between start and stop bits (values arbitrary)
   localparam logic [3:0] OP_PRESSURE = 4'hA;
   localparam logic [3:0] OP_TEMPERATURE = 4'h9;
   localparam logic [3:0] OP_CAL_A = 4'h5;
   localparam logic [3:0] OP_CAL_B = 4'h6;
   localparam logic [3:0] OP_CAL_C = 4'h3;
   localparam logic [3:0] OP_CAL_D = 4'hC;
   // Framing of an instruction
   localparam logic [2:0] START_BITS = 3'h7;
   localparam logic [2:0] STOP_BITS = 3'h0;
   localparam int CMD_LEN = 10;
   // Resynchronising pattern, sent first bit = MSB (value arbitrary, holds no 111)
   localparam logic [20:0] RESET_PATTERN = 21'h0AAAAA;
   localparam int RESET_LEN = 21;
   // Clock counts of the readout and acknowledge phases
   localparam int READ_CLOCKS = 17;
   localparam int ACK_CLOCKS = 2;
   // Factory coefficient defaults (values arbitrary)
   localparam logic [12:0] COEFF_1_DEF = 13'h1A2B;
   localparam logic [12:0] COEFF_2_DEF = 13'h0C35;
   localparam logic [9:0] COEFF_3_DEF = 10'h2F1;
   localparam logic [8:0] COEFF_4_DEF = 9'h0E7;
   localparam logic [11:0] COEFF_5_DEF = 12'h9AB;
   localparam logic [6:0] COEFF_6_DEF = 7'h3C;
   // Timing: core clock, conversion clock, serial clock limit
   localparam int CORE_CLK_KHZ = 125000;
   localparam int CONV_CLK_HZ = 32768;
   localparam int CONV_TIME_MS = 35;
   localparam int BRIDGE_ON_MS = 2;
   localparam int SCLK_MAX_KHZ = 500;
   localparam int CONV_TICKS = CONV_TIME_MS * CONV_CLK_HZ / 1000;
   localparam int BRIDGE_TICKS = BRIDGE_ON_MS * CONV_CLK_HZ / 1000;
   localparam int SCLK_HALF_CYC = (CORE_CLK_KHZ + 2 * SCLK_MAX_KHZ - 1) / (2 * SCLK_MAX_KHZ);
   localparam int MCLK_HALF_CYC = CORE_CLK_KHZ * 1000 / (2 * CONV_CLK_HZ);
   // Host register map
   localparam logic [1:0] REG_CMD = 2'h0;
   localparam logic [1:0] REG_STATUS = 2'h1;
   localparam logic [1:0] REG_RESULT = 2'h2;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_DONE_BIT = 1;
   // Host operations written to the command register
   localparam logic [2:0] HOP_PRESSURE = 3'h0;
   localparam logic [2:0] HOP_TEMPERATURE = 3'h1;
   localparam logic [2:0] HOP_CAL_A = 3'h2;
   localparam logic [2:0] HOP_CAL_B = 3'h3;
   localparam logic [2:0] HOP_CAL_C = 3'h4;
   localparam logic [2:0] HOP_CAL_D = 3'h5;
   localparam logic [2:0] HOP_RESET = 3'h6;
endpackage

/* inc/psr_link_if.sv */
// Three-wire serial link plus conversion clock between sensor and host
`timescale 1ns/1ps
interface psr_link_if;
   logic sclk;
   logic din;
   logic dout;
   logic mclk;
   modport sensor (input sclk, input din, input mclk, output dout);
   modport host (output sclk, output din, output mclk, input dout);
endinterface

/* design/psr_sensor.sv */
// Sensor end: instruction decoder, converter sequencer, calibration store, readout shifter
`timescale 1ns/1ps
// How it works
// - Produce 16-bit raw pressure and raw temperature
// - One converter serves both measurement kinds
// - Hold 64 calibration bits as four words
// - Pack six coefficients into words, MSB first
// - Host reads all four calibration words
// - Host repeatedly acquires pressure and temperature
// - Sample input and shift output on rising clock
// - Host clocks, changes and samples on falling
// - Output content follows the latest instruction
// - Frame: three high, four code, three low
// - Seven instructions: two conversions, four words, reset
// - Acknowledge conversion start by output rising
// - Host gives two clocks then holds low
// - Output falls when the conversion ends
// - Seventeen clocks shift out the 16-bit result
// - Readout pauses with the clock, keeps position
// - Host reads result before next conversion
// - 21-bit pattern resynchronises from any state
// - Host sends reset pattern before each conversion
// - Bridge powered only briefly per measurement
module psr_sensor #(
   parameter int CONV_TICKS = psr_pkg::CONV_TICKS,
   parameter int BRIDGE_TICKS = psr_pkg::BRIDGE_TICKS,
   parameter logic [12:0] COEFF_1 = psr_pkg::COEFF_1_DEF,
   parameter logic [12:0] COEFF_2 = psr_pkg::COEFF_2_DEF,
   parameter logic [9:0] COEFF_3 = psr_pkg::COEFF_3_DEF,
   parameter logic [8:0] COEFF_4 = psr_pkg::COEFF_4_DEF,
   parameter logic [11:0] COEFF_5 = psr_pkg::COEFF_5_DEF,
   parameter logic [6:0] COEFF_6 = psr_pkg::COEFF_6_DEF
) (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic reset_in,
   // Serial link
   psr_link_if.sensor link,
   // Converter front end
   input wire logic [15:0] pressure_level_in,
   input wire logic [15:0] temperature_level_in,
   output logic bridge_power_out,
   output logic sense_resistance_out,
   output logic converting_out,
   output logic resync_out
);
   // Calibration store, read only
   localparam logic [15:0] CAL_WORD_A = {COEFF_1, COEFF_2[12:10]};
   localparam logic [15:0] CAL_WORD_B = {COEFF_2[9:0], COEFF_5[11:6]};
   localparam logic [15:0] CAL_WORD_C = {COEFF_3, COEFF_5[5:0]};
   localparam logic [15:0] CAL_WORD_D = {COEFF_4, COEFF_6};
   localparam logic [4:0] ACK_LAST = 5'(psr_pkg::ACK_CLOCKS - 1);
   localparam logic [4:0] READ_LAST = 5'(psr_pkg::READ_CLOCKS - 1);
   localparam logic [11:0] CONV_LAST = 12'(CONV_TICKS - 1);
   localparam logic [11:0] BRIDGE_LAST = 12'(BRIDGE_TICKS - 1);

   typedef enum logic [1:0] {
      ST_CMD,
      ST_ACK,
      ST_CONV,
      ST_READ
   } psr_dev_state_e;

   typedef struct packed {
      logic [2:0] sclk_sync;
      logic [1:0] din_sync;
      logic [2:0] mclk_sync;
      psr_dev_state_e state;
      logic [20:0] window;
      logic [4:0] bit_cnt;
      logic [11:0] tick_cnt;
      logic [15:0] shift;
      logic measure_temp;
      logic dout;
      logic bridge;
      logic converting;
      logic resync;
   } psr_dev_s;

   psr_dev_s state_reg;
   psr_dev_s state_next;

   // Next-state logic
   always_comb
   begin
      logic sclk_rise;
      logic mclk_rise;
      logic [20:0] win;
      state_next = state_reg;
      state_next.resync = 1'b0;
      // Two-stage synchronisers; stage 0 feeds only stage 1
      state_next.sclk_sync = {state_reg.sclk_sync[1:0], link.sclk};
      state_next.din_sync = {state_reg.din_sync[0], link.din};
      state_next.mclk_sync = {state_reg.mclk_sync[1:0], link.mclk};
      sclk_rise = state_reg.sclk_sync[1] & ~state_reg.sclk_sync[2];
      mclk_rise = state_reg.mclk_sync[1] & ~state_reg.mclk_sync[2];
      win = {state_reg.window[19:0], state_reg.din_sync[1]};

      // Conversion paced by the conversion clock only
      if (state_reg.state == ST_CONV && mclk_rise)
      begin
         state_next.tick_cnt = state_reg.tick_cnt + 12'h001;
         if (state_reg.tick_cnt == BRIDGE_LAST)
         begin
            state_next.bridge = 1'b0; // Bridge off after its short on-time
         end
         if (state_reg.tick_cnt == CONV_LAST)
         begin
            // Same converter, result chosen by measurement kind
            state_next.shift = state_reg.measure_temp ? temperature_level_in : pressure_level_in;
            state_next.dout = 1'b0; // End of conversion
            state_next.state = ST_READ;
            state_next.bit_cnt = 5'h00;
            state_next.converting = 1'b0;
            state_next.bridge = 1'b0;
         end
      end

      // Serial side acts only on rising clock edges
      if (sclk_rise)
      begin
         state_next.window = win;
         unique case (state_reg.state)
            ST_CMD:
            begin
               // Start, code, stop framing
               if (win[9:7] == psr_pkg::START_BITS && win[2:0] == psr_pkg::STOP_BITS)
               begin
                  case (win[6:3])
                     psr_pkg::OP_PRESSURE, psr_pkg::OP_TEMPERATURE:
                     begin
                        state_next.measure_temp = (win[6:3] == psr_pkg::OP_TEMPERATURE);
                        state_next.dout = 1'b1; // Conversion acknowledge
                        state_next.state = ST_ACK;
                        state_next.bit_cnt = 5'h00;
                        state_next.window = 21'h000000;
                     end
                     psr_pkg::OP_CAL_A, psr_pkg::OP_CAL_B, psr_pkg::OP_CAL_C, psr_pkg::OP_CAL_D:
                     begin
                        if (win[6:3] == psr_pkg::OP_CAL_A)
                           state_next.shift = CAL_WORD_A;
                        else if (win[6:3] == psr_pkg::OP_CAL_B)
                           state_next.shift = CAL_WORD_B;
                        else if (win[6:3] == psr_pkg::OP_CAL_C)
                           state_next.shift = CAL_WORD_C;
                        else
                           state_next.shift = CAL_WORD_D;
                        state_next.state = ST_READ;
                        state_next.bit_cnt = 5'h00;
                        state_next.window = 21'h000000;
                     end
                     default:
                     begin
                        state_next.window = win;
                     end
                  endcase
               end
            end
            ST_ACK:
            begin
               // Two clocks after the acknowledge, then convert
               state_next.bit_cnt = state_reg.bit_cnt + 5'h01;
               if (state_reg.bit_cnt == ACK_LAST)
               begin
                  state_next.state = ST_CONV;
                  state_next.tick_cnt = 12'h000;
                  state_next.converting = 1'b1;
                  state_next.bridge = 1'b1;
               end
            end
            ST_CONV:
            begin
               state_next.window = win;
            end
            ST_READ:
            begin
               // Position kept in bit_cnt while the clock pauses
               if (state_reg.bit_cnt == READ_LAST)
               begin
                  state_next.dout = 1'b0; // Idle low after the last clock
                  state_next.state = ST_CMD;
               end
               else
               begin
                  state_next.dout = state_reg.shift[15];
                  state_next.shift = {state_reg.shift[14:0], 1'b0};
                  state_next.bit_cnt = state_reg.bit_cnt + 5'h01;
               end
            end
         endcase
         // Reset pattern wins in every state
         if (win == psr_pkg::RESET_PATTERN)
         begin
            state_next.state = ST_CMD;
            state_next.dout = 1'b0;
            state_next.window = 21'h000000;
            state_next.bridge = 1'b0;
            state_next.converting = 1'b0;
            state_next.resync = 1'b1;
         end
      end
   end

   // State register
   always_ff @(posedge core_clk_in)
   begin
      if (reset_in)
      begin
         state_reg <= '0;
         state_reg.state <= ST_CMD;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // Outputs straight from flops
   assign link.dout = state_reg.dout;
   assign bridge_power_out = state_reg.bridge;
   assign sense_resistance_out = state_reg.measure_temp;
   assign converting_out = state_reg.converting;
   assign resync_out = state_reg.resync;
endmodule // psr_sensor

/* verification/psr_link_properties.sv */
// Timing properties of the link wires between the host end and the sensor end
`timescale 1ns/1ps
module psr_link_properties (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic reset_in,
   // Link wires
   input wire logic sclk,
   input wire logic din,
   input wire logic dout,
   input wire logic mclk
);
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (reset_in);
   // Conversion clock holds high for its half period, then drops
   sequence mclk_high_phase;
      mclk [*3] ##[1:2] !mclk;
   endsequence
   // Host answers the end of conversion with readout clocks
   sequence readout_start;
      ##[1:100] $rose(sclk);
   endsequence
   // Wire checks
   chk_idle_after_reset: assert property ($fell(reset_in) |-> !dout && !sclk && !din)
      else $error("link not idle after reset");
   chk_mclk_free_run: assert property ($rose(mclk) |-> mclk_high_phase)
      else $error("conversion clock phase wrong");
   chk_sclk_high_min: assert property ($rose(sclk) |-> sclk [*8])
      else $error("serial clock high phase short");
   chk_sclk_low_min: assert property ($fell(sclk) |-> !sclk [*8])
      else $error("serial clock low phase short");
   chk_din_on_fall: assert property ($changed(din) |-> !sclk)
      else $error("data input moved while clock high");
   chk_dout_rise_clk: assert property ($rose(dout) |-> sclk)
      else $error("data output rose without clock");
   chk_dout_after_rise: assert property ($changed(dout) && sclk |-> !$past(sclk, 6))
      else $error("data output moved late in clock high");
   chk_eoc_readout: assert property ($fell(dout) && !sclk |-> readout_start)
      else $error("no readout clocks after conversion end");
endmodule // psr_link_properties

/* verification/pressure_sensor_serial_readout_tb_top.sv */
// Bench joining host and sensor ends, driving the host register port
`timescale 1ns/1ps
module pressure_sensor_serial_readout_tb_top;
   typedef struct {logic [2:0] op; logic [15:0] exp; logic sr;} psr_row_s;
   logic core_clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic [1:0] reg_addr = 2'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [15:0] reg_rdata;
   logic [15:0] p_level = 16'h8421;
   logic [15:0] t_level = 16'h5AC3;
   logic bridge, sense_r, conv, resync;
   int num_errors = 0;
   int cmp_count = 0;
   int resync_cnt = 0;
   int bridge_cnt = 0;
   int conv_cnt = 0;
   psr_link_if link ();
   // Both ends and the wire checker
   psr_sensor #(.CONV_TICKS(20), .BRIDGE_TICKS(5)) psr_sensor_inst (.core_clk_in(core_clk_in),
      .reset_in(reset_in), .link(link), .pressure_level_in(p_level), .temperature_level_in(t_level),
      .bridge_power_out(bridge), .sense_resistance_out(sense_r), .converting_out(conv), .resync_out(resync));
   psr_host #(.SCLK_HALF(10), .MCLK_HALF(4), .RESET_FIRST(1'b1)) psr_host_inst (.core_clk_in(core_clk_in),
      .reset_in(reset_in), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_write_in(reg_write),
      .reg_read_in(reg_read), .reg_rdata_out(reg_rdata), .link(link));
   psr_link_properties psr_link_properties_inst (.core_clk_in(core_clk_in), .reset_in(reset_in),
      .sclk(link.sclk), .din(link.din), .dout(link.dout), .mclk(link.mclk));
   // Core clock, 8 ns period
   initial
   begin
      forever #4 core_clk_in = ~core_clk_in;
   end
   // Event counters on the sensor side
   always @(posedge core_clk_in)
   begin
      if (resync === 1'b1) resync_cnt++;
      if (bridge === 1'b1) bridge_cnt++;
      if (conv === 1'b1) conv_cnt++;
   end
   task automatic test_done;
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One-cycle register write and read
   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge core_clk_in);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge core_clk_in);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, output logic [15:0] d);
      @(posedge core_clk_in);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge core_clk_in);
      reg_read <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // Start an operation and poll until done, bounded
   task automatic run_op(input logic [2:0] op, output logic [15:0] res);
      logic [15:0] s;
      bit ok;
      ok = 0;
      wr(psr_pkg::REG_CMD, {13'h0000, op});
      for (int i = 0; i < 3000 && !ok; i++)
      begin
         rd(psr_pkg::REG_STATUS, s);
         if (s[psr_pkg::STAT_DONE_BIT] === 1'b1) ok = 1;
      end
      if (!ok)
      begin
         num_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, s, 16'h0002);
         test_done();
      end
      else
      begin
         rd(psr_pkg::REG_RESULT, res);
      end
   endtask
   initial
   begin
      psr_row_s rows [6];
      logic [15:0] v;
      rows[0] = '{psr_pkg::HOP_PRESSURE, 16'h8421, 1'b0};
      rows[1] = '{psr_pkg::HOP_TEMPERATURE, 16'h5AC3, 1'b1};
      rows[2] = '{psr_pkg::HOP_CAL_A, {psr_pkg::COEFF_1_DEF, psr_pkg::COEFF_2_DEF[12:10]}, 1'b1};
      rows[3] = '{psr_pkg::HOP_CAL_B, {psr_pkg::COEFF_2_DEF[9:0], psr_pkg::COEFF_5_DEF[11:6]}, 1'b1};
      rows[4] = '{psr_pkg::HOP_CAL_C, {psr_pkg::COEFF_3_DEF, psr_pkg::COEFF_5_DEF[5:0]}, 1'b1};
      rows[5] = '{psr_pkg::HOP_CAL_D, {psr_pkg::COEFF_4_DEF, psr_pkg::COEFF_6_DEF}, 1'b1};
      repeat (6) @(posedge core_clk_in);
      reset_in <= 1'b0;
      rd(psr_pkg::REG_STATUS, v);
      cmp16(v, 16'h0000);
      // Every readout kind, with the converter's measurement selection
      foreach (rows[i])
      begin
         run_op(rows[i].op, v);
         cmp16(v, rows[i].exp);
         cmp16({15'h0000, sense_r}, {15'h0000, rows[i].sr});
      end
      cmp16(16'(resync_cnt), 16'h0002);
      // Repeat pressure conversion with a changed level, then reset
      p_level <= 16'hFFFF;
      run_op(psr_pkg::HOP_PRESSURE, v);
      cmp16(v, 16'hFFFF);
      run_op(psr_pkg::HOP_RESET, v);
      cmp16(16'(resync_cnt), 16'h0004);
      // Refused code and unmapped read
      wr(psr_pkg::REG_CMD, 16'h0007);
      rd(psr_pkg::REG_STATUS, v);
      cmp16(v, 16'h0000);
      rd(psr_pkg::REG_CMD, v);
      cmp16(v, {13'h0000, psr_pkg::HOP_RESET});
      rd(2'h3, v);
      cmp16(v, 16'h0000);
      // Reset in mid-conversion, then recover
      wr(psr_pkg::REG_CMD, {13'h0000, psr_pkg::HOP_TEMPERATURE});
      wr(psr_pkg::REG_CMD, {13'h0000, psr_pkg::HOP_PRESSURE});
      rd(psr_pkg::REG_CMD, v);
      cmp16(v, {13'h0000, psr_pkg::HOP_TEMPERATURE});
      repeat (700) @(posedge core_clk_in);
      #1 cmp16({15'h0000, conv}, 16'h0001);
      @(posedge core_clk_in);
      reset_in <= 1'b1;
      repeat (6) @(posedge core_clk_in);
      reset_in <= 1'b0;
      @(posedge core_clk_in);
      #1 cmp16({15'h0000, link.dout}, 16'h0000);
      run_op(psr_pkg::HOP_CAL_D, v);
      cmp16(v, rows[5].exp);
      cmp16({15'h0000, bridge_cnt > 0 && bridge_cnt < conv_cnt}, 16'h0001);
      test_done();
   end
endmodule // pressure_sensor_serial_readout_tb_top
